/* hps_consts.svh */
// Purpose: constants of the host port status flag block
// Assumes: host addresses are three bits wide
// Notes: byte lane addresses swap with the byte order select
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH
`define HPS_ADDR_STATUS 3'h2
`define HPS_ADDR_BYTE_HI 3'h5
`define HPS_ADDR_BYTE_MID 3'h6
`define HPS_ADDR_BYTE_LO 3'h7
`define HPS_BIT_REQ 7
`define HPS_BIT_FLAG3 4
`define HPS_BIT_FLAG2 3
`define HPS_BIT_TRANSMITTER_READY_FLAG 2
`define HPS_BIT_TRANSMIT_EMPTY_FLAG 1
`define HPS_BIT_RECEIVE_FULL_FLAG 0
`define HPS_RST_TRANSMIT_EMPTY_FLAG 1'h1
`define HPS_RST_RECEIVE_FULL_FLAG 1'h0
`define HPS_RST_FLAG 1'h0
`define HPS_RST_BYTE 8'h00
`define HPS_RST_WORD 24'h00_0000
`define HPS_FIFO_DEPTH 8
`define HPS_WORD_W 24
`endif

/* hps_pkg.sv */
// Purpose: shared types of the host port status flag block
// Assumes: 24-bit data words, 8-bit host bytes
// Notes: constants live in hps_consts.svh
package hps_pkg;
    typedef logic [7:0] hps_byte_t;
    typedef logic [23:0] hps_word_t;
    typedef logic [2:0] hps_addr_t;
endpackage

/* hps_fifo.sv */
// Purpose: word fifo in front of the dsp-side transmit register
// Assumes: one clock, synchronous clear
// Notes: full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module hps_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (AW+1)'(D));
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_r];

    // storage has no reset; only pointers and count matter
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (clear_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* hps_req.sv */
// Purpose: host request bit and request pins
// Assumes: flags and enables already registered
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module hps_req (
    input wire logic transmit_empty_flag_i,
    input wire logic receive_full_flag_i,
    input wire logic transmit_request_enable_en_i,
    input wire logic receive_request_enable_en_i,
    input wire logic dual_mode_i,
    output logic req_bit_o,
    output logic host_req_o,
    output logic tx_req_o,
    output logic rx_req_o
);
    logic tx_src;
    logic rx_src;

    assign tx_src = transmit_empty_flag_i && transmit_request_enable_en_i;
    assign rx_src = receive_full_flag_i && receive_request_enable_en_i;
    assign req_bit_o = tx_src || rx_src;
    assign host_req_o = !dual_mode_i && req_bit_o;
    // both dual pins low whenever the bit is low
    assign tx_req_o = dual_mode_i && tx_src;
    assign rx_req_o = dual_mode_i && rx_src;
endmodule
`default_nettype wire

/* hps_status_flags.sv */
// Purpose: host-side status flags and byte paths of a parallel host port
// Assumes: all inputs synchronous to clk_i; resets are synchronous levels
// Notes: status register read at its own host address; reads are registered
`timescale 1ns/1ps
`default_nettype none
`include "hps_consts.svh"
module hps_status_flags (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sw_reset_i,
    input wire logic indiv_reset_i,
    input wire logic stop_reset_i,
    input wire logic [2:0] host_addr_i,
    input wire logic host_rd_i,
    input wire logic host_wr_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    input wire logic init_i,
    input wire logic byte_order_select_i,
    input wire logic transmit_request_enable_i,
    input wire logic receive_request_enable_i,
    input wire logic dual_request_pin_mode_i,
    output logic host_req_o,
    output logic transmit_request_out_o,
    output logic receive_request_out_o,
    input wire logic dsp_flag_three_i,
    input wire logic dsp_flag_two_i,
    output logic [23:0] dsp_rx_data_o,
    output logic dsp_rx_valid_o,
    input wire logic dsp_rx_ack_i,
    input wire logic dsp_tx_valid_i,
    output logic dsp_tx_ready_o,
    input wire logic [23:0] dsp_tx_data_i
);
    logic any_rst;
    logic flag_rst;
    logic transmit_empty_flag_r;
    logic receive_full_flag_r;
    logic dsp_rx_full_r;
    logic flag3_r;
    logic flag2_r;
    logic transmitter_ready_flag;
    logic req_bit;
    logic tx_move;
    logic rx_move;
    logic last_tx_wr;
    logic last_rx_rd;
    logic htx_full_r;
    hps_pkg::hps_word_t htx_r;
    hps_pkg::hps_word_t hrx_r;
    hps_pkg::hps_word_t rx_bytes_r;
    hps_pkg::hps_word_t fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    hps_pkg::hps_byte_t tx_byte_r [3];
    hps_pkg::hps_byte_t status;
    hps_pkg::hps_byte_t rd_val;

    assign any_rst = rst_i || sw_reset_i || indiv_reset_i || stop_reset_i;
    assign flag_rst = rst_i || sw_reset_i;

    // last lane is the top address in either byte order; only its byte changes
    assign last_tx_wr = host_wr_i &&
        (host_addr_i == `HPS_ADDR_BYTE_LO);
    assign last_rx_rd = host_rd_i &&
        (host_addr_i == `HPS_ADDR_BYTE_LO);

    assign transmitter_ready_flag = transmit_empty_flag_r && !dsp_rx_full_r;
    // word moves as soon as bytes are full and the dsp side is free
    assign tx_move = !transmit_empty_flag_r && !dsp_rx_full_r;
    assign rx_move = htx_full_r && !receive_full_flag_r;

    // byte lanes: lane 0 low, lane 2 high
    for (genvar i = 0; i < 3; i++)
    begin : g_lane
        logic [2:0] lane_addr;
        assign lane_addr = byte_order_select_i ? 3'(5 + i) : 3'(7 - i);
        always_ff @(posedge clk_i)
        begin
            if (any_rst)
            begin
                tx_byte_r[i] <= `HPS_RST_BYTE;
            end
            else if (host_wr_i && host_addr_i == lane_addr)
            begin
                tx_byte_r[i] <= host_wdata_i;
            end
        end
    end

    // transmit empty flag
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            transmit_empty_flag_r <= `HPS_RST_TRANSMIT_EMPTY_FLAG;
        end
        else if (tx_move || init_i)
        begin
            transmit_empty_flag_r <= 1'b1;
        end
        else if (last_tx_wr)
        begin
            transmit_empty_flag_r <= 1'b0;
        end
    end

    // dsp-side receive register and its full flag
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            dsp_rx_full_r <= 1'b0;
            hrx_r <= `HPS_RST_WORD;
        end
        else if (tx_move)
        begin
            dsp_rx_full_r <= 1'b1;
            hrx_r <= {tx_byte_r[2], tx_byte_r[1], tx_byte_r[0]};
        end
        else if (dsp_rx_ack_i)
        begin
            dsp_rx_full_r <= 1'b0;
        end
    end

    assign dsp_rx_data_o = hrx_r;
    assign dsp_rx_valid_o = dsp_rx_full_r;

    // dsp words queue here; stalls the core when the host lags
    hps_fifo #(
        .W(`HPS_WORD_W),
        .D(`HPS_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .clear_i(any_rst),
        .in_valid_i(dsp_tx_valid_i),
        .in_ready_o(dsp_tx_ready_o),
        .in_data_i(dsp_tx_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(!htx_full_r || rx_move),
        .out_data_o(fifo_data)
    );

    assign fifo_pop = fifo_valid && (!htx_full_r || rx_move);

    // dsp-side transmit register
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            htx_full_r <= 1'b0;
            htx_r <= `HPS_RST_WORD;
        end
        else if (fifo_pop)
        begin
            htx_full_r <= 1'b1;
            htx_r <= fifo_data;
        end
        else if (rx_move)
        begin
            htx_full_r <= 1'b0;
        end
    end

    // host receive bytes
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            rx_bytes_r <= `HPS_RST_WORD;
        end
        else if (rx_move)
        begin
            rx_bytes_r <= htx_r;
        end
    end

    // receive full flag; a fill wins over a read or initialize
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
        begin
            receive_full_flag_r <= `HPS_RST_RECEIVE_FULL_FLAG;
        end
        else if (rx_move)
        begin
            receive_full_flag_r <= 1'b1;
        end
        else if (last_rx_rd || init_i)
        begin
            receive_full_flag_r <= 1'b0;
        end
    end

    // dsp flags change only on the dsp side
    always_ff @(posedge clk_i)
    begin
        if (flag_rst)
        begin
            flag3_r <= `HPS_RST_FLAG;
            flag2_r <= `HPS_RST_FLAG;
        end
        else
        begin
            flag3_r <= dsp_flag_three_i;
            flag2_r <= dsp_flag_two_i;
        end
    end

    hps_req u_req (
        .transmit_empty_flag_i(transmit_empty_flag_r),
        .receive_full_flag_i(receive_full_flag_r),
        .transmit_request_enable_en_i(transmit_request_enable_i),
        .receive_request_enable_en_i(receive_request_enable_i),
        .dual_mode_i(dual_request_pin_mode_i),
        .req_bit_o(req_bit),
        .host_req_o(host_req_o),
        .tx_req_o(transmit_request_out_o),
        .rx_req_o(receive_request_out_o)
    );

    always_comb
    begin
        status = 8'h00;
        status[`HPS_BIT_REQ] = req_bit;
        status[`HPS_BIT_FLAG3] = flag3_r;
        status[`HPS_BIT_FLAG2] = flag2_r;
        status[`HPS_BIT_TRANSMITTER_READY_FLAG] = transmitter_ready_flag;
        status[`HPS_BIT_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag_r;
        status[`HPS_BIT_RECEIVE_FULL_FLAG] = receive_full_flag_r;
    end

    // a read of empty rx bytes returns stale data, nothing guards it
    always_comb
    begin
        rd_val = 8'h00;
        if (host_addr_i == `HPS_ADDR_STATUS)
        begin
            rd_val = status;
        end
        else if (host_addr_i == `HPS_ADDR_BYTE_MID)
        begin
            rd_val = rx_bytes_r[15:8];
        end
        else if (host_addr_i == `HPS_ADDR_BYTE_HI)
        begin
            rd_val = byte_order_select_i ? rx_bytes_r[7:0] : rx_bytes_r[23:16];
        end
        else if (host_addr_i == `HPS_ADDR_BYTE_LO)
        begin
            rd_val = byte_order_select_i ? rx_bytes_r[23:16] : rx_bytes_r[7:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            host_rdata_o <= 8'h00;
        end
        else if (host_rd_i)
        begin
            host_rdata_o <= rd_val;
        end
    end
endmodule
`default_nettype wire

/* hps_status_checker.sv */
// Purpose: port assertions of the host port status flag block
// Assumes: status byte at host address 2, last byte lane at 7
// Notes: flags are only visible through status reads
`timescale 1ns/1ps
`default_nettype none
module hps_status_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sw_reset_i,
    input wire logic indiv_reset_i,
    input wire logic stop_reset_i,
    input wire logic init_i,
    input wire logic [2:0] host_addr_i,
    input wire logic host_rd_i,
    input wire logic host_wr_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic transmit_request_enable_i,
    input wire logic receive_request_enable_i,
    input wire logic dual_request_pin_mode_i,
    input wire logic host_req_o,
    input wire logic transmit_request_out_o,
    input wire logic receive_request_out_o,
    input wire logic dsp_flag_three_i,
    input wire logic dsp_flag_two_i,
    input wire logic dsp_rx_valid_o
);
    wire soft_w = sw_reset_i | indiv_reset_i | stop_reset_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_stat_rd;
        host_rd_i && host_addr_i == 3'h2;
    endsequence
    sequence s_soft;
        soft_w ##1 !host_wr_i && !soft_w;
    endsequence
    req_bit_a: assert property (s_stat_rd |=> host_rdata_o[7] ==
        $past(host_req_o | transmit_request_out_o | receive_request_out_o))
        else $error("request bit differs from request pins");
    reserved_zero_a: assert property (s_stat_rd |=> host_rdata_o[6:5] == 2'h0)
        else $error("reserved status bits not zero");
    flag_mirror_a: assert property (s_stat_rd and (!$past(rst_i) && !$past(sw_reset_i))
        |=> host_rdata_o[4:3] == $past({dsp_flag_three_i, dsp_flag_two_i}, 2))
        else $error("dsp flags not mirrored");
    ready_flag_a: assert property (s_stat_rd
        |=> host_rdata_o[2] == (host_rdata_o[1] && !$past(dsp_rx_valid_o)))
        else $error("ready flag wrong");
    soft_reset_a: assert property (s_soft ##1 s_stat_rd |=> host_rdata_o[2:0] == 3'h6)
        else $error("flags wrong after reset");
    pass_thru_a: assert property (host_wr_i && host_addr_i == 3'h7 && !dsp_rx_valid_o
        && !soft_w && !init_i ##1 !soft_w && !init_i |=> dsp_rx_valid_o)
        else $error("word not passed to dsp side");
    dual_pins_a: assert property ((transmit_request_out_o | receive_request_out_o)
        |-> dual_request_pin_mode_i && (!transmit_request_out_o || transmit_request_enable_i)
        && (!receive_request_out_o || receive_request_enable_i))
        else $error("dual request pin without enable");
    single_pin_a: assert property (host_req_o |-> !dual_request_pin_mode_i
        && (transmit_request_enable_i || receive_request_enable_i))
        else $error("single request pin without enable");
endmodule
bind hps_status_flags hps_status_checker i_chk (.clk_i, .rst_i, .sw_reset_i, .indiv_reset_i,
    .stop_reset_i, .init_i, .host_addr_i, .host_rd_i, .host_wr_i, .host_rdata_o,
    .transmit_request_enable_i, .receive_request_enable_i, .dual_request_pin_mode_i,
    .host_req_o, .transmit_request_out_o, .receive_request_out_o, .dsp_flag_three_i,
    .dsp_flag_two_i, .dsp_rx_valid_o);
`default_nettype wire

/* hps_host_model.sv */
// Purpose: host processor on the parallel port
// Assumes: one strobe cycle per access
// Notes: write data inverted when idle, so stale bytes never look valid
`timescale 1ns/1ps
`default_nettype none
module hps_host_model (
    input wire logic clk_i,
    input wire logic [7:0] host_rdata_o,
    output logic [2:0] host_addr_i,
    output logic host_rd_i,
    output logic host_wr_i,
    output logic [7:0] host_wdata_i
);
    initial
    begin
        host_addr_i = 3'h0;
        host_rd_i = 1'b0;
        host_wr_i = 1'b0;
        host_wdata_i = 8'h00;
    end
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        host_addr_i <= a;
        host_wr_i <= 1'b1;
        host_wdata_i <= d;
        @(posedge clk_i);
        host_wr_i <= 1'b0;
        host_wdata_i <= ~d;
    endtask
    task automatic get(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        host_addr_i <= a;
        host_rd_i <= 1'b1;
        @(posedge clk_i);
        host_rd_i <= 1'b0;
        @(negedge clk_i);
        d = host_rdata_o;
    endtask
endmodule
`default_nettype wire

/* host_port_status_flags_tb_top.sv */
// Purpose: self-checking bench of the host port status flag block
// Assumes: status at 2, byte lanes 5 to 7, last lane 7
// Notes: random words from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module host_port_status_flags_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, sw_reset_i = 1'b0, indiv_reset_i = 1'b0;
    logic stop_reset_i = 1'b0, init_i = 1'b0, byte_order_select_i = 1'b0;
    logic transmit_request_enable_i = 1'b0, receive_request_enable_i = 1'b0;
    logic dual_request_pin_mode_i = 1'b0, dsp_flag_three_i = 1'b0, dsp_flag_two_i = 1'b0;
    logic dsp_rx_ack_i = 1'b0, dsp_tx_valid_i = 1'b0;
    logic [23:0] dsp_tx_data_i = 24'h00_0000;
    logic [2:0] host_addr_i;
    logic host_rd_i, host_wr_i, host_req_o, transmit_request_out_o, receive_request_out_o;
    logic [7:0] host_wdata_i, host_rdata_o, rdat;
    logic [23:0] dsp_rx_data_o;
    logic dsp_rx_valid_o, dsp_tx_ready_o;
    int seed = 8, error_cnt = 0, checked = 0, cyc = 0;
    always #50 clk_i = ~clk_i;
    hps_status_flags i_dut (.clk_i, .rst_i, .sw_reset_i, .indiv_reset_i, .stop_reset_i,
        .host_addr_i, .host_rd_i, .host_wr_i, .host_wdata_i, .host_rdata_o, .init_i,
        .byte_order_select_i, .transmit_request_enable_i, .receive_request_enable_i,
        .dual_request_pin_mode_i, .host_req_o, .transmit_request_out_o,
        .receive_request_out_o, .dsp_flag_three_i, .dsp_flag_two_i, .dsp_rx_data_o,
        .dsp_rx_valid_o, .dsp_rx_ack_i, .dsp_tx_valid_i, .dsp_tx_ready_o, .dsp_tx_data_i);
    hps_host_model i_host (.clk_i, .host_rdata_o, .host_addr_i, .host_rd_i, .host_wr_i,
        .host_wdata_i);
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end
    function automatic logic [7:0] lane(input logic [23:0] w, input logic [2:0] a, input logic o);
        if (a == 3'h6)
            return w[15:8];
        return ((a == 3'h7) == o) ? w[23:16] : w[7:0];
    endfunction
    task automatic send(input logic [23:0] w);
        // let a new byte order settle before lanes are picked
        @(negedge clk_i);
        for (int a = 5; a < 8; a++)
            i_host.put(a[2:0], lane(w, a[2:0], byte_order_select_i));
    endtask
    task automatic push(input logic [23:0] w, output logic acc);
        @(posedge clk_i);
        dsp_tx_valid_i <= 1'b1;
        dsp_tx_data_i <= w;
        @(negedge clk_i);
        acc = dsp_tx_ready_o;
        @(posedge clk_i);
        dsp_tx_valid_i <= 1'b0;
    endtask
    task automatic ack;
        @(posedge clk_i);
        dsp_rx_ack_i <= 1'b1;
        @(posedge clk_i);
        dsp_rx_ack_i <= 1'b0;
    endtask
    initial
    begin
        logic [23:0] w;
        logic [23:0] q[$];
        logic acc;
        int n;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_i);
            byte_order_select_i <= k[0];
            transmit_request_enable_i <= k[1];
            {dsp_flag_three_i, dsp_flag_two_i} <= 2'($random(seed));
            w = 24'($random(seed));
            send(w);
            repeat (2) @(negedge clk_i);
            chk("dsp rx data", dsp_rx_data_o, w);
            i_host.get(3'h2, rdat);
            chk("status full", rdat, {k[1], 2'h0, dsp_flag_three_i, dsp_flag_two_i, 3'h2});
            w = 24'($random(seed));
            send(w);
            i_host.get(3'h2, rdat);
            chk("status stall", rdat[7:0] & 8'he7, 8'h00);
            ack();
            repeat (2) @(negedge clk_i);
            chk("dsp rx late", dsp_rx_data_o, w);
            ack();
        end
        @(posedge clk_i);
        transmit_request_enable_i <= 1'b0;
        receive_request_enable_i <= 1'b1;
        n = 0;
        do
        begin
            w = 24'($random(seed));
            push(w, acc);
            if (acc)
                q.push_back(w);
            n++;
        end
        while (acc && n < 16);
        chk("fifo refused", acc, 1'b0);
        // eight queued, one holding, one in the receive bytes, then one refused
        chk("fifo depth", 24'(n), 24'h00_000b);
        while (q.size() > 0)
        begin
            w = q.pop_front();
            @(posedge clk_i);
            dual_request_pin_mode_i <= 1'($random(seed));
            i_host.get(3'h2, rdat);
            chk("rx full", rdat[0], 1'b1);
            chk("req pins", {host_req_o, receive_request_out_o, transmit_request_out_o},
                dual_request_pin_mode_i ? 3'h2 : 3'h4);
            for (int a = 5; a < 8; a++)
            begin
                i_host.get(a[2:0], rdat);
                chk("rx byte", rdat, lane(w, a[2:0], byte_order_select_i));
            end
        end
        @(posedge clk_i);
        dual_request_pin_mode_i <= 1'b0;
        transmit_request_enable_i <= 1'b1;
        {dsp_flag_three_i, dsp_flag_two_i} <= 2'h3;
        for (int k = 0; k < 4; k++)
        begin
            w = 24'($random(seed));
            // fill the dsp receive side, then leave tx bytes full before the reset
            send(w);
            send(~w);
            push(w, acc);
            repeat (3) @(posedge clk_i);
            {sw_reset_i, indiv_reset_i, stop_reset_i, init_i} <= 4'h8 >> k;
            @(posedge clk_i);
            {sw_reset_i, indiv_reset_i, stop_reset_i, init_i} <= 4'h0;
            i_host.get(3'h2, rdat);
            chk("after reset", rdat, (k == 3) ? 8'h9a : 8'h9e);
        end
        conclude();
    end
endmodule
`default_nettype wire
